// >>> rtl/p2ca_top.sv
// second enable pin converter assignment register with apb access
//
// Summary of operation
// [RL1] Any of assignment bits 3:0 set turns off the voltage-scaling serial interface on the shared pins.
// [RL2] A converter with a clear assignment bit follows only its register and device-state request.
// [RL3] A converter with a set bit takes state from the pin, qualified by keep-on; all but the io converter take voltage from it too.
// [RL4] Bit 3 set: fet controller uses operating voltage when pin high, sleep voltage when low.
// [RL5] Bit 3 set, pin low, fet keep-on set: low-power unless the sleep voltage selects off.
// [RL6] Bit 2 set: second core converter uses operating voltage pin high, sleep voltage pin low.
// [RL7] Bit 1 set: first core converter uses operating voltage pin high, sleep voltage pin low.
// [RL8] A core converter on the pin, pin low and keep-on set, runs low-power unless sleep is off.
// [RL9] Bit 0 set: io converter on with pin high, otherwise off or low-power with keep-on set.
// [RL10] Bits 7:5 read zero and ignore writes; bit 4 stores its value and steers nothing.
`default_nettype none
module p2ca_top (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic second_enable_input,
	input wire p2ca_pkg::p2ca_conv_t io_reg_req,
	input wire p2ca_pkg::p2ca_conv_t core1_reg_req,
	input wire p2ca_pkg::p2ca_conv_t core2_reg_req,
	input wire p2ca_pkg::p2ca_conv_t fet_reg_req,
	output p2ca_pkg::p2ca_conv_t io_conv,
	output p2ca_pkg::p2ca_conv_t core1_conv,
	output p2ca_pkg::p2ca_conv_t core2_conv,
	output p2ca_pkg::p2ca_conv_t fet_conv,
	output logic sr_if_enable
);
	// ****************************************
	// register state
	// ****************************************
	logic [7:0] second_pin_converter_assign;
	logic [3:0] sleep_keepon_converter_mask;
	logic [7:0] fet_ctrl_operating_voltage;
	logic [7:0] fet_ctrl_sleep_voltage;
	logic [7:0] core1_operating_voltage;
	logic [7:0] core1_sleep_voltage;
	logic [7:0] core2_operating_voltage;
	logic [7:0] core2_sleep_voltage;
	logic [7:0] next_assign;
	logic [3:0] next_keepon;
	logic [7:0] next_fet_op;
	logic [7:0] next_fet_sr;
	logic [7:0] next_core1_op;
	logic [7:0] next_core1_sr;
	logic [7:0] next_core2_op;
	logic [7:0] next_core2_sr;
	logic [31:0] next_prdata;
	logic next_pready;
	logic next_pslverr;
	logic [31:0] rd_word;
	logic addr_hit;
	logic wr_take;
	logic fet_ctrl_sleep_keepon;

	assign fet_ctrl_sleep_keepon = sleep_keepon_converter_mask[p2ca_pkg::FET_BIT]; // RL5

	// ****************************************
	// apb decode
	// ****************************************
	always_comb begin
		addr_hit = 1'b1;
		rd_word = 32'h0000_0000;
		unique case (paddr)
			p2ca_pkg::ASSIGN_ADDR: rd_word[7:0] = second_pin_converter_assign; // RL10
			p2ca_pkg::KEEPON_ADDR: rd_word[3:0] = sleep_keepon_converter_mask;
			p2ca_pkg::FET_OP_ADDR: rd_word[7:0] = fet_ctrl_operating_voltage;
			p2ca_pkg::FET_SR_ADDR: rd_word[7:0] = fet_ctrl_sleep_voltage;
			p2ca_pkg::CORE1_OP_ADDR: rd_word[7:0] = core1_operating_voltage;
			p2ca_pkg::CORE1_SR_ADDR: rd_word[7:0] = core1_sleep_voltage;
			p2ca_pkg::CORE2_OP_ADDR: rd_word[7:0] = core2_operating_voltage;
			p2ca_pkg::CORE2_SR_ADDR: rd_word[7:0] = core2_sleep_voltage;
			p2ca_pkg::STATUS_ADDR: rd_word[8:0] = {sr_if_enable, fet_conv.mode,
				core2_conv.mode, core1_conv.mode, io_conv.mode};
			default: addr_hit = 1'b0;
		endcase
	end

	// only byte lane 0 carries writable register bits, so only its strobe counts
	assign wr_take = psel & penable & pready & pwrite & pstrb[0];

	always_comb begin
		next_assign = second_pin_converter_assign;
		next_keepon = sleep_keepon_converter_mask;
		next_fet_op = fet_ctrl_operating_voltage;
		next_fet_sr = fet_ctrl_sleep_voltage;
		next_core1_op = core1_operating_voltage;
		next_core1_sr = core1_sleep_voltage;
		next_core2_op = core2_operating_voltage;
		next_core2_sr = core2_sleep_voltage;
		// one wait-free access cycle: pready rises the cycle after setup
		next_pready = psel & ~penable;
		next_pslverr = psel & ~penable & ~addr_hit;
		next_prdata = prdata;
		if (psel && !penable && !pwrite)
			next_prdata = rd_word;
		if (wr_take) begin
			unique case (paddr)
				p2ca_pkg::ASSIGN_ADDR: next_assign = pwdata[7:0] & p2ca_pkg::ASSIGN_RW_MASK; // RL10
				p2ca_pkg::KEEPON_ADDR: next_keepon = pwdata[3:0];
				p2ca_pkg::FET_OP_ADDR: next_fet_op = pwdata[7:0];
				p2ca_pkg::FET_SR_ADDR: next_fet_sr = pwdata[7:0];
				p2ca_pkg::CORE1_OP_ADDR: next_core1_op = pwdata[7:0];
				p2ca_pkg::CORE1_SR_ADDR: next_core1_sr = pwdata[7:0];
				p2ca_pkg::CORE2_OP_ADDR: next_core2_op = pwdata[7:0];
				p2ca_pkg::CORE2_SR_ADDR: next_core2_sr = pwdata[7:0];
				default: next_assign = second_pin_converter_assign;
			endcase
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_pin_converter_assign <= p2ca_pkg::ASSIGN_RESET;
			sleep_keepon_converter_mask <= p2ca_pkg::KEEPON_RESET;
			fet_ctrl_operating_voltage <= p2ca_pkg::VOLT_RESET;
			fet_ctrl_sleep_voltage <= p2ca_pkg::VOLT_RESET;
			core1_operating_voltage <= p2ca_pkg::VOLT_RESET;
			core1_sleep_voltage <= p2ca_pkg::VOLT_RESET;
			core2_operating_voltage <= p2ca_pkg::VOLT_RESET;
			core2_sleep_voltage <= p2ca_pkg::VOLT_RESET;
			prdata <= 32'h0000_0000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			second_pin_converter_assign <= next_assign;
			sleep_keepon_converter_mask <= next_keepon;
			fet_ctrl_operating_voltage <= next_fet_op;
			fet_ctrl_sleep_voltage <= next_fet_sr;
			core1_operating_voltage <= next_core1_op;
			core1_sleep_voltage <= next_core1_sr;
			core2_operating_voltage <= next_core2_op;
			core2_sleep_voltage <= next_core2_sr;
			prdata <= next_prdata;
			pready <= next_pready;
			pslverr <= next_pslverr;
		end
	end

	// ****************************************
	// converter selection
	// ****************************************
	p2ca_pkg::p2ca_conv_t next_io;
	p2ca_pkg::p2ca_conv_t next_core1;
	p2ca_pkg::p2ca_conv_t next_core2;
	p2ca_pkg::p2ca_conv_t next_fet;
	logic next_sr_en;

	p2ca_conv_sel #(.HAS_VSEL(1'b0)) u_io_sel ( // RL9
		.follow(second_pin_converter_assign[p2ca_pkg::IO_BIT]),
		.pin(second_enable_input),
		.keepon(sleep_keepon_converter_mask[p2ca_pkg::IO_BIT]),
		.op_v(p2ca_pkg::VOLT_OFF),
		.sr_v(p2ca_pkg::VOLT_OFF),
		.reg_req(io_reg_req),
		.result(next_io)
	);

	p2ca_conv_sel #(.HAS_VSEL(1'b1)) u_core1_sel ( // RL7
		.follow(second_pin_converter_assign[p2ca_pkg::CORE1_BIT]),
		.pin(second_enable_input),
		.keepon(sleep_keepon_converter_mask[p2ca_pkg::CORE1_BIT]),
		.op_v(core1_operating_voltage),
		.sr_v(core1_sleep_voltage),
		.reg_req(core1_reg_req),
		.result(next_core1)
	);

	p2ca_conv_sel #(.HAS_VSEL(1'b1)) u_core2_sel ( // RL6
		.follow(second_pin_converter_assign[p2ca_pkg::CORE2_BIT]),
		.pin(second_enable_input),
		.keepon(sleep_keepon_converter_mask[p2ca_pkg::CORE2_BIT]),
		.op_v(core2_operating_voltage),
		.sr_v(core2_sleep_voltage),
		.reg_req(core2_reg_req),
		.result(next_core2)
	);

	p2ca_conv_sel #(.HAS_VSEL(1'b1)) u_fet_sel ( // RL4
		.follow(second_pin_converter_assign[p2ca_pkg::FET_BIT]),
		.pin(second_enable_input),
		.keepon(fet_ctrl_sleep_keepon),
		.op_v(fet_ctrl_operating_voltage),
		.sr_v(fet_ctrl_sleep_voltage),
		.reg_req(fet_reg_req),
		.result(next_fet)
	);

	// spare bit is kept out on purpose so it cannot block the serial interface
	assign next_sr_en = ~|second_pin_converter_assign[p2ca_pkg::FET_BIT:p2ca_pkg::IO_BIT]; // RL1

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			io_conv <= p2ca_pkg::CONV_RESET;
			core1_conv <= p2ca_pkg::CONV_RESET;
			core2_conv <= p2ca_pkg::CONV_RESET;
			fet_conv <= p2ca_pkg::CONV_RESET;
			sr_if_enable <= 1'b1;
		end else begin
			io_conv <= next_io;
			core1_conv <= next_core1;
			core2_conv <= next_core2;
			fet_conv <= next_fet;
			sr_if_enable <= next_sr_en;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	logic [7:0] asg;
	assign asg = second_pin_converter_assign;

	sequence rd_assign_setup;
		psel && !penable && !pwrite && paddr == p2ca_pkg::ASSIGN_ADDR;
	endsequence

	sequence wr_assign_access;
		wr_take && paddr == p2ca_pkg::ASSIGN_ADDR;
	endsequence

	sr_disable_a: assert property ( // RL1
		@(posedge pclk) disable iff (!presetn)
		##1 sr_if_enable == ($past(asg[3:0]) == 4'h0))
		else $error("serial interface enable does not match assignment bits");

	// the release edge still takes the reset branch, so that edge starts no check
	reg_path_a: assert property ( // RL2
		@(posedge pclk) disable iff (!presetn)
		presetn && !asg[p2ca_pkg::CORE2_BIT] |=> core2_conv == $past(core2_reg_req))
		else $error("unassigned converter left the register path");

	pin_follow_a: assert property ( // RL3
		@(posedge pclk) disable iff (!presetn)
		asg[p2ca_pkg::IO_BIT] && second_enable_input ##1 asg[p2ca_pkg::IO_BIT]
		|-> io_conv.mode == p2ca_pkg::p2ca_on)
		else $error("assigned io converter not on with pin high");

	fet_volt_a: assert property ( // RL4
		@(posedge pclk) disable iff (!presetn)
		asg[p2ca_pkg::FET_BIT] |=> fet_conv.volt == ($past(second_enable_input) ?
			$past(fet_ctrl_operating_voltage) : $past(fet_ctrl_sleep_voltage)))
		else $error("fet controller voltage source wrong");

	fet_lowpower_a: assert property ( // RL5
		@(posedge pclk) disable iff (!presetn)
		asg[p2ca_pkg::FET_BIT] && !second_enable_input && fet_ctrl_sleep_keepon
		&& fet_ctrl_sleep_voltage != p2ca_pkg::VOLT_OFF
		|=> fet_conv.mode == p2ca_pkg::p2ca_lowpower)
		else $error("fet controller not in low power");

	core2_off_a: assert property ( // RL6
		@(posedge pclk) disable iff (!presetn)
		asg[p2ca_pkg::CORE2_BIT] && second_enable_input
		&& core2_operating_voltage == p2ca_pkg::VOLT_OFF
		|=> core2_conv.mode == p2ca_pkg::p2ca_off)
		else $error("second core converter not off with operating voltage off");

	core1_high_a: assert property ( // RL7
		@(posedge pclk) disable iff (!presetn)
		asg[p2ca_pkg::CORE1_BIT] && second_enable_input
		&& core1_operating_voltage != p2ca_pkg::VOLT_OFF
		|=> core1_conv.mode == p2ca_pkg::p2ca_on
		&& core1_conv.volt == $past(core1_operating_voltage))
		else $error("first core converter not on at operating voltage");

	core_lowpower_a: assert property ( // RL8
		@(posedge pclk) disable iff (!presetn)
		asg[p2ca_pkg::CORE1_BIT] && !second_enable_input
		&& sleep_keepon_converter_mask[p2ca_pkg::CORE1_BIT]
		&& core1_sleep_voltage != p2ca_pkg::VOLT_OFF
		|=> core1_conv.mode == p2ca_pkg::p2ca_lowpower)
		else $error("first core converter not in low power");

	io_low_a: assert property ( // RL9
		@(posedge pclk) disable iff (!presetn)
		asg[p2ca_pkg::IO_BIT] && !second_enable_input
		|=> io_conv.mode == ($past(sleep_keepon_converter_mask[p2ca_pkg::IO_BIT]) ?
			p2ca_pkg::p2ca_lowpower : p2ca_pkg::p2ca_off))
		else $error("io converter wrong with pin low");

	reserved_read_a: assert property ( // RL10
		@(posedge pclk) disable iff (!presetn)
		rd_assign_setup |=> pready && prdata[31:5] == 27'h0000000)
		else $error("reserved assignment bits read nonzero");

	spare_store_a: assert property ( // RL10
		@(posedge pclk) disable iff (!presetn)
		wr_assign_access |=> asg == ($past(pwdata[7:0]) & p2ca_pkg::ASSIGN_RW_MASK))
		else $error("assignment write not stored as masked value");
endmodule
`default_nettype wire

// >>> rtl/p2ca_pkg.sv
// constants and types for the second-pin converter assignment block
`default_nettype none
package p2ca_pkg;
	// ****************************************
	// bus and register map
	// ****************************************
	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;
	localparam logic [7:0] ASSIGN_ADDR = 8'h48;
	localparam logic [7:0] KEEPON_ADDR = 8'h60;
	localparam logic [7:0] FET_OP_ADDR = 8'h64;
	localparam logic [7:0] FET_SR_ADDR = 8'h68;
	localparam logic [7:0] CORE1_OP_ADDR = 8'h6C;
	localparam logic [7:0] CORE1_SR_ADDR = 8'h70;
	localparam logic [7:0] CORE2_OP_ADDR = 8'h74;
	localparam logic [7:0] CORE2_SR_ADDR = 8'h78;
	localparam logic [7:0] STATUS_ADDR = 8'h7C;

	// ****************************************
	// field layout and reset values
	// ****************************************
	localparam int IO_BIT = 0;
	localparam int CORE1_BIT = 1;
	localparam int CORE2_BIT = 2;
	localparam int FET_BIT = 3;
	localparam int SPARE_BIT = 4;
	localparam logic [7:0] ASSIGN_RW_MASK = 8'h1F;
	localparam logic [7:0] ASSIGN_RESET = 8'h00;
	localparam logic [3:0] KEEPON_RESET = 4'h0;
	localparam logic [7:0] VOLT_RESET = 8'h00;
	localparam logic [7:0] VOLT_OFF = 8'h00;
	localparam int STATUS_SR_BIT = 8;

	// ****************************************
	// converter request and result
	// ****************************************
	typedef enum logic [1:0] {
		p2ca_off = 2'b00,
		p2ca_on = 2'b01,
		p2ca_lowpower = 2'b10
	} p2ca_mode_t;

	typedef struct packed {
		p2ca_mode_t mode;
		logic [7:0] volt;
	} p2ca_conv_t;

	localparam p2ca_conv_t CONV_RESET = '{mode: p2ca_off, volt: 8'h00};
endpackage
`default_nettype wire

// >>> rtl/p2ca_conv_sel.sv
// per-converter source selection between register path and pin path
`default_nettype none
module p2ca_conv_sel #(
	parameter bit HAS_VSEL = 1'b1
) (
	input wire logic follow,
	input wire logic pin,
	input wire logic keepon,
	input wire logic [7:0] op_v,
	input wire logic [7:0] sr_v,
	input wire p2ca_pkg::p2ca_conv_t reg_req,
	output p2ca_pkg::p2ca_conv_t result
);
	always_comb begin
		result = reg_req; // RL2
		if (follow) begin // RL3
			if (!HAS_VSEL) begin
				// io converter: no voltage pair, on/off/low-power only
				result.volt = reg_req.volt;
				if (pin)
					result.mode = p2ca_pkg::p2ca_on;
				else if (keepon)
					result.mode = p2ca_pkg::p2ca_lowpower;
				else
					result.mode = p2ca_pkg::p2ca_off;
			end else if (pin) begin
				result.volt = op_v;
				result.mode = (op_v == p2ca_pkg::VOLT_OFF) ? p2ca_pkg::p2ca_off :
					p2ca_pkg::p2ca_on;
			end else begin
				result.volt = sr_v;
				if (sr_v == p2ca_pkg::VOLT_OFF)
					result.mode = p2ca_pkg::p2ca_off;
				else if (keepon) // RL5 RL8
					result.mode = p2ca_pkg::p2ca_lowpower;
				else
					result.mode = p2ca_pkg::p2ca_on;
			end
		end
	end
endmodule
`default_nettype wire

// >>> test/p2ca_pin_host.sv
// model of the host processor that drives the second enable pin level
`default_nettype none
module p2ca_pin_host (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic level_req,
	output logic second_enable_input
);
	timeunit 1ns;
	timeprecision 1ps;
	// launched just after an edge, like any synchronous host output
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			second_enable_input <= 1'b0;
		end else begin
			second_enable_input <= level_req;
		end
	end
endmodule
`default_nettype wire

// >>> test/p2ca_top_tb.sv
// self-checking bench for the second-pin converter assignment block
`default_nettype none
module p2ca_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [7:0] asg;
		logic [3:0] kp;
		logic pin;
		logic [9:0] io, c1, c2, fet;
		logic sr;
	} p2ca_row_t;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, pin_req, pin, sr_en, err;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] pstrb;
	p2ca_pkg::p2ca_conv_t io_req, c1_req, c2_req, fet_req, io_conv, c1_conv, c2_conv, fet_conv;
	int n_errors = 0;
	int comparisons = 0;
	logic [7:0] va [6] = '{8'h64, 8'h68, 8'h6C, 8'h70, 8'h74, 8'h78};
	logic [7:0] vd [6] = '{8'h31, 8'h11, 8'h32, 8'h00, 8'h33, 8'h13};
	// ****************************************
	// rows: assign, keep-on, pin -> io, core1, core2, fet, serial enable
	// ****************************************
	p2ca_row_t rows [7] = '{
		'{8'h00, 4'h0, 1'b1, 10'h150, 10'h251, 10'h152, 10'h153, 1'b1},
		'{8'h0F, 4'h0, 1'b1, 10'h150, 10'h132, 10'h133, 10'h131, 1'b0},
		'{8'h0F, 4'h0, 1'b0, 10'h050, 10'h000, 10'h113, 10'h111, 1'b0},
		'{8'h0F, 4'hF, 1'b0, 10'h250, 10'h000, 10'h213, 10'h211, 1'b0},
		'{8'h10, 4'hF, 1'b0, 10'h150, 10'h251, 10'h152, 10'h153, 1'b1},
		'{8'h08, 4'h8, 1'b0, 10'h150, 10'h251, 10'h152, 10'h211, 1'b0},
		'{8'h05, 4'h1, 1'b1, 10'h150, 10'h251, 10'h133, 10'h153, 1'b0}};

	p2ca_top i_p2ca_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .second_enable_input(pin),
		.io_reg_req(io_req), .core1_reg_req(c1_req), .core2_reg_req(c2_req),
		.fet_reg_req(fet_req), .io_conv(io_conv), .core1_conv(c1_conv),
		.core2_conv(c2_conv), .fet_conv(fet_conv), .sr_if_enable(sr_en));
	p2ca_pin_host i_p2ca_pin_host (.pclk(pclk), .presetn(presetn), .level_req(pin_req),
		.second_enable_input(pin));

	// ****************************************
	// tasks
	// ****************************************
	task automatic summarize();
		if (n_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	// request held until pready is seen high at a rising edge
	task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// no wait-state count assumed: only the watchdog ends a stuck access
		do begin
			@(posedge pclk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// ****************************************
	// clock, watchdog, sequence
	// ****************************************
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end
	initial begin
		#20000;
		n_errors++;
		summarize();
	end
	initial begin
		presetn = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'hF;
		pin_req = 1'b0;
		io_req = 10'h150;
		c1_req = 10'h251;
		c2_req = 10'h152;
		fet_req = 10'h153;
		repeat (6) @(posedge pclk);
		presetn <= 1'b1;
		apb(1'b0, p2ca_pkg::ASSIGN_ADDR, 32'h0);
		chk(rd, 32'h0);
		chk(sr_en, 1'b1);
		foreach (va[i]) apb(1'b1, va[i], {24'h0, vd[i]});
		apb(1'b0, p2ca_pkg::CORE2_SR_ADDR, 32'h0);
		chk(rd, 32'h13);
		foreach (rows[i]) begin
			apb(1'b1, p2ca_pkg::ASSIGN_ADDR, {24'h0, rows[i].asg});
			apb(1'b1, p2ca_pkg::KEEPON_ADDR, {28'h0, rows[i].kp});
			pin_req <= rows[i].pin;
			repeat (4) @(posedge pclk);
			chk(io_conv, rows[i].io);
			chk(c1_conv, rows[i].c1);
			chk(c2_conv, rows[i].c2);
			chk(fet_conv, rows[i].fet);
			chk(sr_en, rows[i].sr);
			apb(1'b0, p2ca_pkg::STATUS_ADDR, 32'h0);
			chk(rd, {23'h0, rows[i].sr, rows[i].fet[9:8], rows[i].c2[9:8],
				rows[i].c1[9:8], rows[i].io[9:8]});
		end
		// reserved bits, refused strobe, unmapped place
		apb(1'b1, p2ca_pkg::ASSIGN_ADDR, 32'hFFFF_FFFF);
		apb(1'b0, p2ca_pkg::ASSIGN_ADDR, 32'h0);
		chk(rd, 32'h1F);
		pstrb <= 4'h0;
		apb(1'b1, p2ca_pkg::ASSIGN_ADDR, 32'h0);
		pstrb <= 4'hF;
		apb(1'b0, p2ca_pkg::ASSIGN_ADDR, 32'h0);
		chk(rd, 32'h1F);
		apb(1'b0, 8'h4C, 32'h0);
		chk({rd[30:0], err}, 32'h1);
		// io voltage tracks the request while the pin steers its state
		apb(1'b1, p2ca_pkg::CORE2_OP_ADDR, 32'h0);
		pin_req <= 1'b1;
		io_req <= 10'h15A;
		repeat (4) @(posedge pclk);
		chk(io_conv, 10'h15A);
		chk(c2_conv, 10'h000);
		chk(sr_en, 1'b0);
		// pin low with keep-on on the first core only
		apb(1'b1, p2ca_pkg::CORE1_SR_ADDR, 32'h21);
		apb(1'b1, p2ca_pkg::KEEPON_ADDR, 32'h2);
		pin_req <= 1'b0;
		repeat (4) @(posedge pclk);
		chk(c1_conv, 10'h221);
		chk(io_conv, 10'h05A);
		// second reset in mid-run
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		chk(sr_en, 1'b1);
		chk(fet_conv, 10'h000);
		presetn <= 1'b1;
		apb(1'b0, p2ca_pkg::ASSIGN_ADDR, 32'h0);
		chk(rd, 32'h0);
		summarize();
	end
endmodule
`default_nettype wire
